//--- rtl/tofg_params.svh
`ifndef TOFG_PARAMS_SVH
`define TOFG_PARAMS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define TOFG_OCFS_IDX 12'h004
`define TOFG_OFF0_IDX 12'h005
`define TOFG_OFF1_IDX 12'h006
`define TOFG_OFF2_IDX 12'h007
`define TOFG_STAT_IDX 12'h008
`define TOFG_REG_RESET 16'h0000

// ---------------------------------------------------------------
// Select register bit positions
// ---------------------------------------------------------------
`define TOFG_FP0_POS_BIT 0
`define TOFG_FP0_POL_BIT 1
`define TOFG_CLK0_POL_BIT 2
`define TOFG_FP1_POS_BIT 3
`define TOFG_FP1_POL_BIT 4
`define TOFG_CLK1_POL_BIT 5
`define TOFG_FP2_POS_BIT 6
`define TOFG_FP2_POL_BIT 7

// ---------------------------------------------------------------
// Frame timing in ticks of the 32.768 MHz timing phase
// ---------------------------------------------------------------
`define TOFG_LAST_PH 12'hfff
`define TOFG_FP0_WIDTH 12'h008
`define TOFG_FP1_WIDTH 12'h004
`define TOFG_FP2_WIDTH 12'h002
`define TOFG_SONET_WIDTH 12'h002
`define TOFG_CHAN_TICKS_2M 12'h080
`define TOFG_PULSE_TICKS_4M 12'h008
`define TOFG_RATE_16M 2'h3

`endif

//--- rtl/tofg_pkg.sv
`default_nettype none
`include "tofg_params.svh"

package tofg_pkg;
   // Offset frame pulse register layout
   typedef struct packed {
      logic [4:0] unused;
      logic sonet_rate_pulse_enable;
      logic [7:0] offset_channel_count;
      logic [1:0] offset_rate_select;
   } tofg_off_cfg_type;

   // Generated clock and frame pulse outputs
   typedef struct packed {
      logic clock_out_zero;
      logic clock_out_one;
      logic frame_pulse_out_zero;
      logic frame_pulse_out_one;
      logic frame_pulse_out_two;
      logic [2:0] offset_frame_pulse_output;
   } tofg_out_type;
endpackage

`default_nettype wire

//--- rtl/tofg_top.sv
// The APB interface to the registers is this design's own decision.
`default_nettype none
`include "tofg_params.svh"

// Notes on behaviour
// - Third pulse straddles or starts at boundary
// - Second clock edge polarity at frame boundary
// - Bit ten: 19.44 MHz pulse on offset two
// - Offset placed count channels after boundary
// - Control bits select offset rate and width
module tofg_top
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic phase_tick,
   input wire logic frame_start,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output tofg_pkg::tofg_out_type timing_out
);
   import tofg_pkg::*;

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------

   // Pulse window test with wrap around the frame
   function automatic logic pulse_on(input logic [11:0] ph, input logic [11:0] start, input logic [11:0] width);
      logic [11:0] rel;
      rel = ph - start;
      pulse_on = (rel < width);
   endfunction

   // Map an APB address to a register index, all ones when misaligned or above bit 13
   function automatic logic [11:0] reg_index(input logic [15:0] addr);
      reg_index = (addr[15:14] == 2'b00 && addr[1:0] == 2'b00) ? addr[13:2] : 12'hfff;
   endfunction

   // ---------------------------------------------------------------
   // Register file over APB
   // ---------------------------------------------------------------
   logic [15:0] ocfs_r;
   logic [15:0] ocfs_nxt;
   tofg_off_cfg_type off_r [3];
   tofg_off_cfg_type off_nxt [3];
   logic [11:0] ph_r;
   logic [11:0] ph_nxt;
   tofg_out_type out_r;
   tofg_out_type out_nxt;
   logic [11:0] idx;
   logic acc;
   logic hit;
   logic [2:0] offs_pulse;

   assign idx = reg_index(paddr);
   assign acc = psel && penable;
   assign hit = (idx == `TOFG_OCFS_IDX) || (idx >= `TOFG_OFF0_IDX && idx <= `TOFG_STAT_IDX);

   // Zero wait state answer, error on unmapped or status writes
   always_comb
   begin
      pready = acc;
      pslverr = acc && (!hit || (pwrite && idx == `TOFG_STAT_IDX));
      prdata = 32'h0000_0000;
      case (idx)
         `TOFG_OCFS_IDX: prdata = {16'h0000, ocfs_r};
         `TOFG_OFF0_IDX: prdata = {16'h0000, off_r[0]};
         `TOFG_OFF1_IDX: prdata = {16'h0000, off_r[1]};
         `TOFG_OFF2_IDX: prdata = {16'h0000, off_r[2]};
         `TOFG_STAT_IDX: prdata = {20'h0_0000, ph_r};
         default: prdata = 32'h0000_0000;
      endcase
   end

   // Next register values on a write access
   always_comb
   begin
      ocfs_nxt = ocfs_r;
      off_nxt = off_r;
      if (acc && pwrite)
      begin
         case (idx)
            `TOFG_OCFS_IDX: ocfs_nxt = pwdata[15:0];
            `TOFG_OFF0_IDX: off_nxt[0] = pwdata[15:0];
            `TOFG_OFF1_IDX: off_nxt[1] = pwdata[15:0];
            `TOFG_OFF2_IDX: off_nxt[2] = pwdata[15:0];
            default: ocfs_nxt = ocfs_r;
         endcase
      end
   end

   // Register storage
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         ocfs_r <= `TOFG_REG_RESET;
         off_r[0] <= `TOFG_REG_RESET;
         off_r[1] <= `TOFG_REG_RESET;
         off_r[2] <= `TOFG_REG_RESET;
      end
      else
      begin
         ocfs_r <= ocfs_nxt;
         off_r <= off_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Frame phase counter
   // ---------------------------------------------------------------

   // Counts timing ticks, realigned by the frame boundary
   always_comb
   begin
      ph_nxt = ph_r;
      if (frame_start)
         ph_nxt = 12'h000;
      else if (phase_tick)
         ph_nxt = ph_r + 12'h001;
   end

   // ---------------------------------------------------------------
   // Offset frame pulses
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_off
         logic [1:0] rate;
         logic [7:0] cnt;
         logic [11:0] start;
         logic [11:0] width;
         logic pol;
         logic pos;
         logic act;
         logic lvl;

         // Rate, width and channel placement; bits 15-11 unused
         always_comb
         begin
            rate = off_r[gi].offset_rate_select;
            cnt = off_r[gi].offset_channel_count & (8'hff >> (2'h3 - rate));
            width = (rate == `TOFG_RATE_16M) ? `TOFG_FP2_WIDTH : (`TOFG_PULSE_TICKS_4M >> rate);
            start = 12'({4'h0, cnt} << (3'h7 - {1'b0, rate}));
            case (rate)
               2'h0:
               begin
                  pol = ocfs_r[`TOFG_FP0_POL_BIT];
                  pos = ocfs_r[`TOFG_FP0_POS_BIT];
               end
               2'h1:
               begin
                  pol = ocfs_r[`TOFG_FP1_POL_BIT];
                  pos = ocfs_r[`TOFG_FP1_POS_BIT];
               end
               default:
               begin
                  pol = ocfs_r[`TOFG_FP2_POL_BIT];
                  pos = ocfs_r[`TOFG_FP2_POS_BIT];
               end
            endcase
            if (!pos)
               start = start - (width >> 1);
            act = pulse_on(ph_nxt, start, width);
            if (gi == 2 && off_r[gi].sonet_rate_pulse_enable)
               lvl = !pulse_on(ph_nxt, 12'h000, `TOFG_SONET_WIDTH);
            else
               lvl = pol ? act : !act;
         end

         // One driver per bit of the shared pulse vector
         assign offs_pulse[gi] = lvl;
      end
   endgenerate

   // ---------------------------------------------------------------
   // Reference clocks and frame pulses
   // ---------------------------------------------------------------

   // Output values for the coming phase
   always_comb
   begin
      out_nxt.clock_out_zero = ph_nxt[2] ^ ocfs_r[`TOFG_CLK0_POL_BIT];
      out_nxt.clock_out_one = ph_nxt[1] ^ ocfs_r[`TOFG_CLK1_POL_BIT];
      out_nxt.frame_pulse_out_zero = !(ocfs_r[`TOFG_FP0_POL_BIT] ^ pulse_on(ph_nxt,
         ocfs_r[`TOFG_FP0_POS_BIT] ? 12'h000 : 12'h000 - (`TOFG_FP0_WIDTH >> 1), `TOFG_FP0_WIDTH));
      out_nxt.frame_pulse_out_one = !(ocfs_r[`TOFG_FP1_POL_BIT] ^ pulse_on(ph_nxt,
         ocfs_r[`TOFG_FP1_POS_BIT] ? 12'h000 : 12'h000 - (`TOFG_FP1_WIDTH >> 1), `TOFG_FP1_WIDTH));
      out_nxt.frame_pulse_out_two = !(ocfs_r[`TOFG_FP2_POL_BIT] ^ pulse_on(ph_nxt,
         ocfs_r[`TOFG_FP2_POS_BIT] ? 12'h000 : 12'h000 - (`TOFG_FP2_WIDTH >> 1), `TOFG_FP2_WIDTH));
      out_nxt.offset_frame_pulse_output = offs_pulse;
   end

   // Phase and output registers
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         ph_r <= `TOFG_LAST_PH;
         out_r <= '0;
      end
      else
      begin
         ph_r <= ph_nxt;
         out_r <= out_nxt;
      end
   end

   assign timing_out = out_r;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_fp2_pos;
      @(posedge ref_clk) disable iff (!rst_b)
      (ph_r == 12'h000 && ocfs_r[`TOFG_FP2_POS_BIT] && $stable(ocfs_r))
      |-> (timing_out.frame_pulse_out_two == ocfs_r[`TOFG_FP2_POL_BIT]);
   endproperty
   a_fp2_pos: assert property (p_fp2_pos) else $error("third pulse not active at boundary");

   property p_fp2_straddle;
      @(posedge ref_clk) disable iff (!rst_b)
      (ph_r == `TOFG_LAST_PH && !ocfs_r[`TOFG_FP2_POS_BIT] && $stable(ocfs_r))
      |-> (timing_out.frame_pulse_out_two == ocfs_r[`TOFG_FP2_POL_BIT]);
   endproperty
   a_fp2_straddle: assert property (p_fp2_straddle) else $error("third pulse does not straddle");

   property p_clk1_edge;
      @(posedge ref_clk) disable iff (!rst_b)
      ($past(ph_r) == `TOFG_LAST_PH && ph_r == 12'h000 && $past(rst_b, 2) && $stable(ocfs_r)
       && $past(ocfs_r, 2) == ocfs_r)
      |-> (timing_out.clock_out_one == ocfs_r[`TOFG_CLK1_POL_BIT])
          && ($past(timing_out.clock_out_one) != ocfs_r[`TOFG_CLK1_POL_BIT]);
   endproperty
   a_clk1_edge: assert property (p_clk1_edge) else $error("second clock edge off boundary");

   property p_sonet;
      @(posedge ref_clk) disable iff (!rst_b)
      (off_r[2].sonet_rate_pulse_enable && ph_r == 12'h001 && $stable(off_r[2]))
      |-> !timing_out.offset_frame_pulse_output[2];
   endproperty
   a_sonet: assert property (p_sonet) else $error("19.44 MHz pulse missing at boundary");

   property p_offset_place;
      @(posedge ref_clk) disable iff (!rst_b)
      (off_r[0][1:0] == 2'h0 && off_r[0][9:7] == 3'h0 && ocfs_r[`TOFG_FP0_POS_BIT]
       && ph_r == {off_r[0][6:2], 7'h00} && $stable(off_r[0]) && $stable(ocfs_r))
      |-> (timing_out.offset_frame_pulse_output[0] == ocfs_r[`TOFG_FP0_POL_BIT]);
   endproperty
   a_offset_place: assert property (p_offset_place) else $error("offset pulse misplaced");

   property p_rate_width;
      @(posedge ref_clk) disable iff (!rst_b)
      (off_r[1][1:0] == 2'h3 && ph_r == {off_r[1][9:2], 4'h2} && ocfs_r[`TOFG_FP2_POS_BIT]
       && $stable(off_r[1]) && $stable(ocfs_r))
      |-> (timing_out.offset_frame_pulse_output[1] != ocfs_r[`TOFG_FP2_POL_BIT]);
   endproperty
   a_rate_width: assert property (p_rate_width) else $error("16 Mbps pulse too wide");

   property p_unused_bits;
      @(posedge ref_clk) disable iff (!rst_b)
      (off_r[0][15:11] != 5'h00 && off_r[0][10:0] == 11'h000 && ocfs_r[`TOFG_FP0_POS_BIT] && ph_r == 12'h000
       && $stable(off_r[0]) && $stable(ocfs_r))
      |-> (timing_out.offset_frame_pulse_output[0] == ocfs_r[`TOFG_FP0_POL_BIT]);
   endproperty
   a_unused_bits: assert property (p_unused_bits) else $error("unused bits changed pulse");

endmodule

`default_nettype wire

//--- verif/tofg_pulse_sink.sv
`default_nettype none

// ----------------------------------------
// Downstream device counting frame pulses
// ----------------------------------------
module tofg_pulse_sink
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic active_level,
   input wire tofg_pkg::tofg_out_type timing_in,
   output var int pulse_count
);
   timeunit 1ns;
   timeprecision 1ps;
   import tofg_pkg::*;
   logic prev_r;

   // Count each entry into the active level of the third pulse
   always @(posedge ref_clk)
   begin
      prev_r <= timing_in.frame_pulse_out_two;
      if (!rst_b)
         pulse_count <= 0;
      else if (timing_in.frame_pulse_out_two == active_level && prev_r != active_level)
         pulse_count <= pulse_count + 1;
   end
endmodule

`default_nettype wire

//--- verif/tb_tdm_output_clock_frame_pulse_gen.sv
`default_nettype none

module tb_tdm_output_clock_frame_pulse_gen;
   timeunit 1ns;
   timeprecision 1ps;
   import tofg_pkg::*;
   logic ref_clk = 0, rst_b = 0, phase_tick = 0, frame_start = 0;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [31:0] rnd = 32'h0000_c09d;
   tofg_out_type timing_out;
   logic [15:0] sel = 16'h0000;
   logic [15:0] off [3] = '{default: 16'h0000};
   logic [11:0] m_ph = 12'hfff, ph_snap;
   logic m_upd = 0;
   int err_count = 0, check_count = 0, wskip = 0, fp2_seen;

   always #20 ref_clk = ~ref_clk;

   tofg_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .phase_tick(phase_tick), .frame_start(frame_start),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timing_out(timing_out));
   tofg_pulse_sink u_sink (.ref_clk(ref_clk), .rst_b(rst_b), .active_level(sel[7]),
      .timing_in(timing_out), .pulse_count(fp2_seen));

   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // Pulse level from start tick, width and controlling pulse index
   function automatic logic pulse(input logic [11:0] ph, st, input int w, k);
      logic [11:0] d;
      d = ph - st + (sel[3 * k] ? 12'h000 : 12'(w / 2));
      return (d < 12'(w)) ? sel[3 * k + 1] : !sel[3 * k + 1];
   endfunction

   function automatic tofg_out_type f_exp(input logic [11:0] ph);
      tofg_out_type o;
      int r;
      o.clock_out_zero = ph[2] ^ sel[2];
      o.clock_out_one = ph[1] ^ sel[5];
      o.frame_pulse_out_zero = pulse(ph, 12'h000, 8, 0);
      o.frame_pulse_out_one = pulse(ph, 12'h000, 4, 1);
      o.frame_pulse_out_two = pulse(ph, 12'h000, 2, 2);
      for (int n = 0; n < 3; n++)
      begin
         r = int'(off[n][1:0]);
         o.offset_frame_pulse_output[n] = pulse(ph, 12'(off[n][9:2]) << (7 - r),
            (r == 0) ? 8 : (r == 1) ? 4 : 2, (r > 2) ? 2 : r);
      end
      if (off[2][10])
         o.offset_frame_pulse_output[2] = !(ph < 12'h002);
      return o;
   endfunction

   // Phase tracking and random timing stimulus
   always @(posedge ref_clk)
   begin
      rnd = xs(rnd);
      m_upd <= rst_b & (phase_tick | frame_start);
      if (!rst_b)
         m_ph <= 12'hfff;
      else if (frame_start)
         m_ph <= 12'h000;
      else if (phase_tick)
         m_ph <= m_ph + 12'h001;
      phase_tick <= rnd[1:0] != 2'h0;
      frame_start <= rnd[14:2] == 13'h0000;
   end

   // Compare outputs after each phase step, skipping config changes
   always @(negedge ref_clk)
      if (wskip > 0)
         wskip--;
      else if (m_upd)
         chk(32'(timing_out), 32'(f_exp(m_ph)));

   // ----------------------------------------
   // Checks and bus tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t mismatch %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
         @(posedge ref_clk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      er = pslverr;
      ph_snap = m_ph;
      wskip = 2;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16)
      begin
         err_count++;
         report_and_stop();
      end
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
      chk(32'(er), 32'(exp_err));
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk(32'(er), 32'h0000_0000);
      if (a == 16'h0010)
         sel = d[15:0];
      else
         off[(a >> 2) - 5] = d[15:0];
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int i = 4; i < 8; i++)
         rd_chk(16'(4 * i), 32'h0000_0000, 1'b0);
      apb(1'b0, 16'h0020, 32'h0000_0000);
      chk(rd, 32'(ph_snap));
      rd_chk(16'h0024, 32'h0000_0000, 1'b1);
      rd_chk(16'h0015, 32'h0000_0000, 1'b1);
      apb(1'b1, 16'h0020, 32'h0000_0123);
      chk(32'(er), 32'h0000_0001);
      for (int i = 0; i < 8; i++)
      begin
         wr_reg(16'h0010, rnd);
         for (int n = 0; n < 3; n++)
            wr_reg(16'h0014 + 16'(4 * n), {21'h00_0000, rnd[10] & (n == 2),
               rnd[9:2] & 8'((32 << ((i + n) % 4)) - 1), 2'((i + n) % 4)});
         for (int n = 0; n < 3; n++)
            rd_chk(16'h0014 + 16'(4 * n), {16'h0000, off[n]}, 1'b0);
         repeat (5000) @(posedge ref_clk);
      end
      // Unused offset bits set on purpose: pulses must not move
      wr_reg(16'h0010, rnd | 32'h0000_0001);
      wr_reg(16'h0014, 32'h0000_f800);
      rd_chk(16'h0014, 32'h0000_f800, 1'b0);
      repeat (6000) @(posedge ref_clk);
      chk(32'(fp2_seen > 0), 32'h0000_0001);
      report_and_stop();
   end
endmodule

`default_nettype wire
